//--- spi_front_regs.svh
// Constants for the serial front end: byte layout, array sizes, sync depth.
// Assumes inclusion by the package and the design modules only.
`ifndef SPI_FRONT_REGS_SVH
`define SPI_FRONT_REGS_SVH
`define BYTE_BITS       4'd8
`define BIT_CNT_W       3
`define BIT_CNT_LAST    3'd7
`define ARRAY_BYTES     524288
`define ARRAY_ADDR_W    19
`define ID_PAGE_BYTES   512
`define ID_ADDR_W       9
`define PROT_LEVEL_W    2
`define PROT_NONE       2'h0
`define SYNC_STAGES     2
`endif

//--- spi_front_pkg.sv
// Types for the serial front end; its pin synchroniser uses none of them.
// Assumes the constants header is on the include path.
`include "spi_front_regs.svh"
package spi_front_pkg;
    typedef struct packed {
        logic sck;
        logic sdi;
        logic cs_n;
        logic pause_n;
        logic freeze_n;
    } pins_t;

    typedef enum logic [1:0] {
        ST_WAIT_EDGE = 2'b00,
        ST_IDLE      = 2'b01,
        ST_ACTIVE    = 2'b10,
        ST_PAUSED    = 2'b11
    } link_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } byte_evt_t;
endpackage

//--- pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes pins are quiet levels relative to clk_i; first stage read only here.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 5
) (
    input  wire logic         clk_i,   // System clock
    input  wire logic         rst_i,   // Async reset, active high
    input  wire logic [W-1:0] d_i,     // Raw pins
    output logic      [W-1:0] q_o      // Synchronised pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } st_t;
    st_t st_r;
    st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    // Reset value is a constant; idle-high pins settle after two edges
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule

//--- spi_eeprom_front.sv
// Serial slave front end: shifts bytes in and out of an SPI bus master.
// Assumes memory and command decode sit behind the byte ports; pins async.
//
// Operation
// - Output changes only on serial clock fall
// - Input bits captured on serial clock rise
// - Deselected means output released
// - Deselect gives standby unless write running
// - Power-up needs chip-select falling edge first
// - Pause keeps selection, releases output, ignores inputs
// - No pause while deselected
// - Freeze pin locks protect level bits
// - Bytes assembled most significant bit first
// - First bit on first rise after select
// - Read data from first fall after command
// - Modes 0 and 3 both supported
// - Main array is 524288 bytes
// - Separate lockable 512-byte identification page
// - Pause starts only with serial clock low
// - Deselect during pause resets protocol state
`timescale 1ns/1ps
`include "spi_front_regs.svh"
module spi_eeprom_front #(
    parameter int ARRAY_BYTES   = `ARRAY_BYTES,
    parameter int ID_PAGE_BYTES = `ID_PAGE_BYTES
) (
    input  wire logic       clk_i,            // 40 MHz system clock
    input  wire logic       rst_i,            // Power-on reset, async high
    input  wire logic       sck_i,            // Serial clock pin
    input  wire logic       sdi_i,            // Serial data in pin
    input  wire logic       cs_n_i,           // Chip select pin, low active
    input  wire logic       pause_n_i,        // Pause pin, low active
    input  wire logic       freeze_n_i,       // Protect freeze pin, low active
    input  wire logic       write_busy_i,     // Internal write cycle running
    input  wire logic       tx_load_i,        // Load next output byte
    input  wire logic [7:0] tx_byte_i,        // Output byte from core
    input  wire logic       prot_wr_i,        // Core requests protect update
    input  wire logic [1:0] prot_wdata_i,     // New protect level
    output logic            sdo_o,            // Serial data out
    output logic            sdo_oe_n_o,       // Output enable, low drives
    output logic [7:0]      rx_byte_o,        // Last assembled byte
    output logic            rx_valid_o,       // One-cycle byte strobe
    output logic            rx_first_o,       // Byte is the first of frame
    output logic            frame_end_o,      // One-cycle deselect strobe
    output logic            tx_req_o,         // Core should load a byte
    output logic            selected_o,       // Device selected
    output logic            standby_o,        // Standby power state
    output logic            paused_o,         // Pause condition held
    output logic            protect_level_hi, // Protect level high bit
    output logic            protect_level_lo  // Protect level low bit
);
    localparam int AW  = $clog2(ARRAY_BYTES);
    localparam int IDW = $clog2(ID_PAGE_BYTES);

    typedef struct packed {
        spi_front_pkg::pins_t       prev;
        spi_front_pkg::link_state_t st;
        logic [`BIT_CNT_W-1:0]      bit_cnt;
        logic [7:0]                 rx_sh;
        logic [7:0]                 tx_sh;
        logic                       first;
        logic                       tx_armed;
        logic                       sdo;
        logic                       sdo_oe_n;
        logic [7:0]                 rx_byte;
        logic                       rx_valid;
        logic                       rx_first;
        logic                       frame_end;
        logic                       tx_req;
        logic                       standby;
        logic                       paused;
        logic [`PROT_LEVEL_W-1:0]   prot;
    } state_t;

    state_t               st_r;
    state_t               st_nxt;
    spi_front_pkg::pins_t pin;
    logic [4:0]           pin_raw;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cs_fall;
    logic                 pause_fall;

    assign pin_raw = {sck_i, sdi_i, cs_n_i, pause_n_i, freeze_n_i};

    // Sync flops reset low: a select held low since power-up shows no edge
    pin_sync #(.W(5)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin)
    );

    function automatic logic rise(input logic prev, input logic now);
        return !prev && now;
    endfunction

    function automatic logic fall(input logic prev, input logic now);
        return prev && !now;
    endfunction

    // MSB first: each new bit enters at the bottom
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b);
        return {sh[6:0], b};
    endfunction

    // Frame teardown on deselect; protect level and standby left alone
    function automatic state_t drop_frame(input state_t s);
        state_t r;
        r           = s;
        r.st        = spi_front_pkg::ST_IDLE;
        r.frame_end = 1'b1;
        r.sdo_oe_n  = 1'b1;
        r.bit_cnt   = '0;
        r.first     = 1'b1;
        r.tx_armed  = 1'b0;
        return r;
    endfunction

    // Edges compare the synced pin with its copy from one clock earlier
    assign sck_rise   = rise(st_r.prev.sck, pin.sck);
    assign sck_fall   = fall(st_r.prev.sck, pin.sck);
    assign cs_fall    = fall(st_r.prev.cs_n, pin.cs_n);
    assign pause_fall = fall(st_r.prev.pause_n, pin.pause_n);

    always_comb begin
        st_nxt           = st_r;
        st_nxt.prev      = pin;
        st_nxt.rx_valid  = 1'b0;
        st_nxt.frame_end = 1'b0;
        st_nxt.tx_req    = 1'b0;
        // Writes while frozen are dropped, not deferred until release
        if (prot_wr_i && pin.freeze_n) begin
            st_nxt.prot = prot_wdata_i;
        end
        if (tx_load_i) begin
            st_nxt.tx_sh    = tx_byte_i;
            st_nxt.tx_armed = 1'b1;
        end
        unique case (st_r.st)
            spi_front_pkg::ST_WAIT_EDGE: begin
                st_nxt.sdo_oe_n = 1'b1;
                // A select held low since power-up gives no edge here
                if (cs_fall) begin
                    st_nxt.st = spi_front_pkg::ST_ACTIVE;
                end
            end
            spi_front_pkg::ST_IDLE: begin
                st_nxt.sdo_oe_n = 1'b1;
                st_nxt.standby  = !write_busy_i;
                if (cs_fall) begin
                    st_nxt.st       = spi_front_pkg::ST_ACTIVE;
                    st_nxt.standby  = 1'b0;
                end
            end
            spi_front_pkg::ST_ACTIVE: begin
                st_nxt.standby = 1'b0;
                if (pin.cs_n) begin
                    st_nxt = drop_frame(st_nxt);
                end else if (pause_fall && !pin.sck) begin
                    // A pause asked for with the clock high is not remembered
                    st_nxt.st       = spi_front_pkg::ST_PAUSED;
                    st_nxt.sdo_oe_n = 1'b1;
                end else if (sck_rise) begin
                    // Mode 0 and 3 both sample on the rising edge
                    st_nxt.rx_sh   = shift_in(st_r.rx_sh, pin.sdi);
                    st_nxt.bit_cnt = st_r.bit_cnt + 3'd1;
                    if (st_r.bit_cnt == `BIT_CNT_LAST) begin
                        st_nxt.rx_byte  = shift_in(st_r.rx_sh, pin.sdi);
                        st_nxt.rx_valid = 1'b1;
                        st_nxt.rx_first = st_r.first;
                        st_nxt.first    = 1'b0;
                        st_nxt.tx_req   = 1'b1;
                    end
                end else if (sck_fall && st_r.tx_armed) begin
                    // Mode 3 idles high: its first fall precedes any data
                    st_nxt.sdo      = st_r.tx_sh[7];
                    st_nxt.tx_sh    = {st_r.tx_sh[6:0], 1'b0};
                    st_nxt.sdo_oe_n = 1'b0;
                end
            end
            spi_front_pkg::ST_PAUSED: begin
                st_nxt.sdo_oe_n = 1'b1;
                if (pin.cs_n) begin
                    st_nxt = drop_frame(st_nxt);
                end else if (pin.pause_n && !pin.sck) begin
                    // Count and shifters untouched: resume at the same bit
                    st_nxt.st       = spi_front_pkg::ST_ACTIVE;
                    st_nxt.sdo_oe_n = !st_r.tx_armed;
                end
            end
        endcase
        st_nxt.paused = (st_nxt.st == spi_front_pkg::ST_PAUSED);
    end

    // Pin copy resets low like the sync flops, so no false fall follows reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r          <= '0;
            st_r.st       <= spi_front_pkg::ST_WAIT_EDGE;
            st_r.sdo_oe_n <= 1'b1;
            st_r.first    <= 1'b1;
            st_r.standby  <= 1'b1;
            st_r.prot     <= `PROT_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdo_o            = st_r.sdo;
    assign sdo_oe_n_o       = st_r.sdo_oe_n;
    assign rx_byte_o        = st_r.rx_byte;
    assign rx_valid_o       = st_r.rx_valid;
    assign rx_first_o       = st_r.rx_first;
    assign frame_end_o      = st_r.frame_end;
    assign tx_req_o         = st_r.tx_req;
    assign selected_o       = st_r.st[1];
    assign standby_o        = st_r.standby;
    assign paused_o         = st_r.paused;
    assign protect_level_hi = st_r.prot[1];
    assign protect_level_lo = st_r.prot[0];
endmodule

//--- spi_front_properties.sv
// Checker for the serial front end, bound to its top module.
// Assumes pins are slow against clk_i: 2 sync flops plus edge detect.
`timescale 1ns/1ps
module spi_front_chk (
    input wire logic clk_i,            // Clock
    input wire logic rst_i,            // Reset
    input wire logic sck_i,            // Serial clock
    input wire logic cs_n_i,           // Select
    input wire logic freeze_n_i,       // Freeze
    input wire logic write_busy_i,     // Write running
    input wire logic sdo_o,            // Data out
    input wire logic sdo_oe_n_o,       // Drive, low
    input wire logic rx_valid_o,       // Byte strobe
    input wire logic selected_o,       // Selected
    input wire logic standby_o,        // Standby
    input wire logic paused_o,         // Paused
    input wire logic protect_level_hi, // Level hi
    input wire logic protect_level_lo  // Level lo
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_select; $fell(cs_n_i) ##1 !cs_n_i [*4]; endsequence
    property p_select; s_select |-> selected_o; endproperty
    a_select: assert property (p_select) else $error("select missed");
    property p_hiz; !selected_o && !$past(selected_o) |-> sdo_oe_n_o; endproperty
    a_hiz: assert property (p_hiz) else $error("driven while idle");
    property p_phiz; paused_o && $past(paused_o) |-> sdo_oe_n_o; endproperty
    a_phiz: assert property (p_phiz) else $error("driven while paused");
    property p_nop; cs_n_i [*5] |-> !paused_o; endproperty
    a_nop: assert property (p_nop) else $error("paused while idle");
    property p_stby;
        !selected_o && !write_busy_i && !$past(selected_o) && !$past(write_busy_i)
            |-> standby_o;
    endproperty
    a_stby: assert property (p_stby) else $error("no standby");
    property p_fall; $changed(sdo_o) && !sdo_oe_n_o |-> !$past(sck_i, 2); endproperty
    a_fall: assert property (p_fall) else $error("out not on fall");
    property p_rise; rx_valid_o |-> $past(sck_i, 2) && !$past(sck_i, 6); endproperty
    a_rise: assert property (p_rise) else $error("in not on rise");
    property p_frz;
        !freeze_n_i && !$past(freeze_n_i, 4)
            |=> $stable({protect_level_hi, protect_level_lo});
    endproperty
    a_frz: assert property (p_frz) else $error("level moved");
endmodule
bind spi_eeprom_front spi_front_chk u_chk (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .sck_i            (sck_i),
    .cs_n_i           (cs_n_i),
    .freeze_n_i       (freeze_n_i),
    .write_busy_i     (write_busy_i),
    .sdo_o            (sdo_o),
    .sdo_oe_n_o       (sdo_oe_n_o),
    .rx_valid_o       (rx_valid_o),
    .selected_o       (selected_o),
    .standby_o        (standby_o),
    .paused_o         (paused_o),
    .protect_level_hi (protect_level_hi),
    .protect_level_lo (protect_level_lo)
);

//--- spi_master_model.sv
// Bus master model: drives clock, data, select and pause at 200 ns per bit.
// Assumes the bench calls its tasks; all changes follow a clk_i rise.
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic       clk_i,      // Bench clock
    input  wire logic       sdo_i,      // Device data out
    input  wire logic       sdo_oe_n_i, // Device drive, low
    output logic            sck_o,      // Serial clock
    output logic            sdi_o,      // Serial data
    output logic            cs_n_o,     // Select, low
    output logic            pause_n_o   // Pause, low
);
    logic       cpol = 1'b0;
    logic [7:0] got = 8'h00;
    wire        line = sdo_oe_n_i ? 1'b1 : sdo_i; // Pull-up when released
    initial begin
        sck_o = 1'b0;
        sdi_o = 1'b0;
        cs_n_o = 1'b0; // Low from power-up
        pause_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic sel(input logic pol);
        cpol = pol;
        sck_o <= pol;
        tick(4);
        cs_n_o <= 1'b0;
        tick(8);
    endtask
    task automatic desel();
        sck_o <= cpol;
        tick(4);
        cs_n_o <= 1'b1;
        tick(12);
    endtask
    task automatic pause(input logic v);
        sck_o <= 1'b0;
        tick(4);
        pause_n_o <= v;
        tick(4);
    endtask
    task automatic bits(input logic [7:0] d, input int n, input int pz);
        for (int i = 7; i > 7 - n; i--) begin
            sck_o <= 1'b0;
            sdi_o <= d[i];
            tick(4);
            if (i == pz) begin
                pause(1'b0);
                sdi_o <= ~d[i];
                sck_o <= 1'b1; // Must be ignored
                tick(4);
                pause(1'b1);
                sdi_o <= d[i];
                tick(2);
            end
            sck_o <= 1'b1;
            tick(2);
            got <= {got[6:0], line};
            tick(2);
        end
    endtask
endmodule

//--- spi_eeprom_serial_front_end_tb.sv
// Bench for the serial front end against the master model.
// Assumes a 40 MHz clock; a trivial core echoes load on each request.
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic freeze_n_i = 1'b1;
    logic write_busy_i = 1'b0;
    logic tx_load_i = 1'b0;
    logic prot_wr_i = 1'b0;
    logic [7:0] tx_byte_i = 8'h00;
    logic [1:0] prot_wdata_i = 2'h0;
    logic sck_i, sdi_i, cs_n_i, pause_n_i, sdo_o, sdo_oe_n_o, rx_valid_o, rx_first_o;
    logic frame_end_o, tx_req_o, selected_o, standby_o, paused_o;
    logic protect_level_hi, protect_level_lo, fst = 1'b0;
    logic [7:0] rx_byte_o;
    int rx_cnt = 0, ps_cnt = 0, fe_cnt = 0, num_errors = 0, cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    spi_master_model M (
        .clk_i      (clk_i),
        .sdo_i      (sdo_o),
        .sdo_oe_n_i (sdo_oe_n_o),
        .sck_o      (sck_i),
        .sdi_o      (sdi_i),
        .cs_n_o     (cs_n_i),
        .pause_n_o  (pause_n_i)
    );
    spi_eeprom_front DUT (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .sck_i            (sck_i),
        .sdi_i            (sdi_i),
        .cs_n_i           (cs_n_i),
        .pause_n_i        (pause_n_i),
        .freeze_n_i       (freeze_n_i),
        .write_busy_i     (write_busy_i),
        .tx_load_i        (tx_load_i),
        .tx_byte_i        (tx_byte_i),
        .prot_wr_i        (prot_wr_i),
        .prot_wdata_i     (prot_wdata_i),
        .sdo_o            (sdo_o),
        .sdo_oe_n_o       (sdo_oe_n_o),
        .rx_byte_o        (rx_byte_o),
        .rx_valid_o       (rx_valid_o),
        .rx_first_o       (rx_first_o),
        .frame_end_o      (frame_end_o),
        .tx_req_o         (tx_req_o),
        .selected_o       (selected_o),
        .standby_o        (standby_o),
        .paused_o         (paused_o),
        .protect_level_hi (protect_level_hi),
        .protect_level_lo (protect_level_lo)
    );
    always @(posedge clk_i) begin
        tx_load_i <= tx_req_o;
        if (rx_valid_o) begin
            rx_cnt++;
            fst <= rx_first_o;
        end
        if (paused_o) ps_cnt++;
        if (frame_end_o) fe_cnt++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_powerup();
        M.bits(8'ha5, 8, -1);
        check(8'(rx_cnt), 8'h00);
        check(selected_o, 1'b0);
        M.desel();
    endtask
    task automatic t_frame(input logic pol);
        int n0;
        n0 = rx_cnt;
        tx_byte_i <= 8'h3c;
        M.sel(pol);
        check(standby_o, 1'b0);
        M.bits(8'ha5, 8, -1);
        M.tick(3);
        check(rx_byte_o, 8'ha5);
        check(fst, 1'b1);
        M.bits(8'h5a, 8, -1);
        M.tick(3);
        check(M.got, 8'h3c);
        check(fst, 1'b0);
        check(8'(rx_cnt - n0), 8'h02);
        write_busy_i <= pol;
        M.desel();
        check(sdo_oe_n_o, 1'b1);
        check(standby_o, {7'h00, !pol});
    endtask
    task automatic t_pause();
        int p0;
        p0 = ps_cnt;
        write_busy_i <= 1'b0;
        M.sel(1'b0);
        M.bits(8'hc3, 8, 4);
        M.tick(3);
        check(rx_byte_o, 8'hc3);
        check(8'(ps_cnt > p0), 8'h01);
        M.desel();
    endtask
    task automatic t_abort();
        int f0;
        M.sel(1'b0);
        M.bits(8'hff, 3, -1);
        M.pause(1'b0);
        f0 = fe_cnt;
        M.desel();
        check(8'(fe_cnt - f0), 8'h01);
        M.pause(1'b1);
        M.pause(1'b0);
        check(paused_o, 1'b0);
        M.pause(1'b1);
        M.sel(1'b0);
        M.bits(8'h81, 8, -1);
        M.tick(3);
        check(rx_byte_o, 8'h81);
        check(fst, 1'b1);
        M.desel();
    endtask
    task automatic wr_prot(input logic [1:0] v);
        prot_wdata_i <= v;
        prot_wr_i <= 1'b1;
        M.tick(1);
        prot_wr_i <= 1'b0;
        M.tick(3);
    endtask
    task automatic t_freeze();
        freeze_n_i <= 1'b0;
        M.tick(4);
        wr_prot(2'h3);
        check({protect_level_hi, protect_level_lo}, 2'h0);
        freeze_n_i <= 1'b1;
        M.tick(4);
        wr_prot(2'h2);
        check({protect_level_hi, protect_level_lo}, 2'h2);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        M.tick(4);
        t_powerup();
        t_frame(1'b0);
        t_frame(1'b1);
        t_pause();
        t_abort();
        t_freeze();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
endmodule
